// ---- hdl/cpd_map.svh ----
// Constants for the console power-up configuration decoder.
// Assumes a 10 MHz clock.
`ifndef CPD_MAP_SVH
`define CPD_MAP_SVH
`define CPD_CLK_HZ 10000000
`define CPD_BAUD_CODES 10
`define CPD_TEXT_ROWS 24
`define CPD_TOTAL_ROWS 25
`define CPD_COLUMNS 80
`define CPD_CHAR_W 7
`define CPD_CHAR_H 8
`define CPD_DESCENDERS 2
`define CPD_CELL_W 9
`define CPD_CELL_H 12
`define CPD_HSWEEP_60_HZ 19400
`define CPD_HSWEEP_50_HZ 18000
`define CPD_KBD_DATA_BITS 8
`define CPD_KBD_STOP_BITS 1
`define CPD_KBD_BAUD_MIN 50
`define CPD_KBD_BAUD_MAX 9600
`define CPD_KBD_BAUD_DEF 9600
`define CPD_HSWEEP_60_CYC (`CPD_CLK_HZ / `CPD_HSWEEP_60_HZ)
`define CPD_HSWEEP_50_CYC (`CPD_CLK_HZ / `CPD_HSWEEP_50_HZ)
`define CPD_HSYNC_CYC 40
`define CPD_VSYNC_LINES 3
`define CPD_SW_CURSOR_BLK 4
`define CPD_SW_CURSOR_BLINK 5
`define CPD_SW_STATUS_KEEP 6
`define CPD_SW_FREQ_60 7
`define CPD_SW_WORD7 0
`define CPD_SW_NO_MODEM 1
`define CPD_SW_ONE_STOP 2
`define CPD_SW_NO_PARITY 3
`define CPD_SW_ODD 4
`define CPD_SW_STICK 5
`define CPD_SW_NATIVE 6
`define CPD_SW_FULL_DUPLEX 7
`endif

// ---- hdl/cpd_pkg.sv ----
// Types for the console power-up configuration decoder.
// Assumes cpd_map.svh is on the include path.
package cpd_pkg;
    typedef struct packed {
        logic [3:0] baud_code;
        logic cursor_block;
        logic cursor_blink;
        logic status_keep;
        logic freq_60;
        logic word_7bit;
        logic modem_ctrl;
        logic two_stop;
        logic parity_en;
        logic parity_odd;
        logic parity_stick;
        logic native_mode;
        logic full_duplex;
        logic vsync_high;
        logic hsync_high;
        logic line_diff;
    } cpd_cfg_s;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } cpd_key_s;
endpackage : cpd_pkg

// ---- hdl/cpd_decoder.sv ----
// Console power-up configuration decoder with keyboard receiver and sync timing.
// Assumes switches read 1 when off, jumpers read 1 when joined at 2-3.
// How it works
// R1: Four off-as-one baud switches, first is LSB, codes 0-9 pick 19200 to 110.
// R2: Bank one switch five on gives block cursor, off gives underline.
// R3: Bank one switch six on makes cursor blink, off keeps it steady.
// R4: Status row shows at start; switch seven off hides it on a key.
// R5: Bank one switch eight on selects 60 Hz, off selects 50 Hz.
// R6: Horizontal sweep runs at 19.4 kHz for 60 Hz, 18 kHz for 50 Hz.
// R7: Bank two: switch one on 7-bit, switch three on one stop bit.
// R8: Bank two switch two on disables modem control, off enables it.
// R9: Bank two switch four on no parity; switch five on odd parity.
// R10: Bank two switch six on forces stick mark parity bit.
// R11: Bank two switch seven on native mode, off emulation mode.
// R12: Bank two switch eight on full duplex, off half duplex with echo.
// R13: Vertical jumper 1-2 gives active-low vsync, 2-3 active-high.
// R14: Horizontal jumper 1-2 gives active-low hsync, 2-3 active-high.
// R15: Keyboard frames are async, 8 data bits then one stop bit.
// R16: One active-high bell output sounds while asserted.
// R17: Screen is 24 rows plus status row by 80 columns, 9x12 cells.
// R18: Line standard jumper 1-2 single-ended, 2-3 differential.
// R19: Settings are sampled at reset release and held until next reset.
`timescale 1ns/1ps
`include "cpd_map.svh"
module cpd_decoder (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] first_config_switch_bank,
    input wire logic [7:0] second_config_switch_bank,
    input wire logic line_standard_jumper,
    input wire logic horizontal_polarity_jumper,
    input wire logic vertical_polarity_jumper,
    input wire logic kbd_serial_in,
    input wire logic [15:0] kbd_bit_cycles,
    input wire logic bell_request,
    output cpd_pkg::cpd_cfg_s cfg,
    output logic [14:0] baud_rate,
    output logic status_visible,
    output cpd_pkg::cpd_key_s key,
    output logic kbd_bell,
    output logic hsync,
    output logic vsync,
    output logic [6:0] text_col,
    output logic [4:0] text_row
);
    import cpd_pkg::*;

    function automatic logic [14:0] baud_of(input logic [3:0] code);
        case (code)
            4'h0: baud_of = 15'h4B00;
            4'h1: baud_of = 15'h2580;
            4'h2: baud_of = 15'h12C0;
            4'h3: baud_of = 15'h0960;
            4'h4: baud_of = 15'h0708;
            4'h5: baud_of = 15'h04B0;
            4'h6: baud_of = 15'h0258;
            4'h7: baud_of = 15'h012C;
            4'h8: baud_of = 15'h0096;
            4'h9: baud_of = 15'h006E;
            default: baud_of = 15'h2580;
        endcase
    endfunction : baud_of

    // Two-stage synchronisers on the switch, jumper and keyboard serial pins
    logic [19:0] pin_meta_reg;
    logic [19:0] pin_sync_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_meta_reg <= '1;
            pin_sync_reg <= '1;
        end else if (clk_en) begin
            pin_meta_reg <= {kbd_serial_in, line_standard_jumper, horizontal_polarity_jumper,
                vertical_polarity_jumper, second_config_switch_bank, first_config_switch_bank};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    logic [7:0] b1;
    logic [7:0] b2;
    logic kbd_rx;
    assign b1 = pin_sync_reg[7:0];
    assign b2 = pin_sync_reg[15:8];
    assign kbd_rx = pin_sync_reg[19];

    // Capture once, a few cycles after reset release so sync stages are settled
    logic [1:0] cap_cnt_reg;
    logic cap_done_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cap_cnt_reg <= 2'h0;
            cap_done_reg <= 1'b0;
        end else if (clk_en && !cap_done_reg) begin
            cap_cnt_reg <= cap_cnt_reg + 2'h1;
            if (cap_cnt_reg == 2'h2) begin
                cap_done_reg <= 1'b1; // R19
            end
        end
    end
    logic cap_now;
    assign cap_now = clk_en && !cap_done_reg && cap_cnt_reg == 2'h2;

    cpd_cfg_s cfg_next;
    always_comb begin
        cfg_next.baud_code = b1[3:0]; // R1
        cfg_next.cursor_block = !b1[`CPD_SW_CURSOR_BLK]; // R2
        cfg_next.cursor_blink = !b1[`CPD_SW_CURSOR_BLINK]; // R3
        cfg_next.status_keep = !b1[`CPD_SW_STATUS_KEEP]; // R4
        cfg_next.freq_60 = !b1[`CPD_SW_FREQ_60]; // R5
        cfg_next.word_7bit = !b2[`CPD_SW_WORD7]; // R7
        cfg_next.two_stop = b2[`CPD_SW_ONE_STOP]; // R7
        cfg_next.modem_ctrl = b2[`CPD_SW_NO_MODEM]; // R8
        cfg_next.parity_en = b2[`CPD_SW_NO_PARITY]; // R9
        cfg_next.parity_odd = !b2[`CPD_SW_ODD]; // R9
        cfg_next.parity_stick = !b2[`CPD_SW_STICK]; // R10
        cfg_next.native_mode = !b2[`CPD_SW_NATIVE]; // R11
        cfg_next.full_duplex = !b2[`CPD_SW_FULL_DUPLEX]; // R12
        cfg_next.vsync_high = pin_sync_reg[16]; // R13
        cfg_next.hsync_high = pin_sync_reg[17]; // R14
        cfg_next.line_diff = pin_sync_reg[18]; // R18
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg <= '0;
            baud_rate <= 15'h4B00;
        end else if (cap_now) begin
            cfg <= cfg_next; // R19
            baud_rate <= baud_of(cfg_next.baud_code); // R1
        end
    end

    // Keyboard receiver: start, 8 data LSB first, 1 stop
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} cpd_rx_e;
    cpd_rx_e rx_state_reg;
    logic [15:0] rx_cnt_reg;
    logic [2:0] rx_bit_reg;
    logic [7:0] rx_shift_reg;
    logic rx_tick;
    assign rx_tick = rx_cnt_reg == 16'h0;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg <= 16'h0;
            rx_bit_reg <= 3'h0;
            rx_shift_reg <= 8'h0;
            key <= '0;
        end else if (clk_en) begin
            key.valid <= 1'b0;
            if (!rx_tick) begin
                rx_cnt_reg <= rx_cnt_reg - 16'h1;
            end
            case (rx_state_reg)
                RX_IDLE: begin
                    if (!kbd_rx) begin
                        rx_state_reg <= RX_START;
                        rx_cnt_reg <= {1'b0, kbd_bit_cycles[15:1]};
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        rx_state_reg <= kbd_rx ? RX_IDLE : RX_DATA;
                        rx_cnt_reg <= kbd_bit_cycles;
                        rx_bit_reg <= 3'h0;
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        rx_shift_reg <= {kbd_rx, rx_shift_reg[7:1]}; // R15
                        rx_cnt_reg <= kbd_bit_cycles;
                        rx_bit_reg <= rx_bit_reg + 3'h1;
                        if (rx_bit_reg == 3'h7) begin
                            rx_state_reg <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_tick) begin
                        rx_state_reg <= RX_IDLE;
                        if (kbd_rx) begin
                            key.data <= rx_shift_reg; // R15
                            key.valid <= 1'b1;
                        end
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // Status row shown from start, hidden on first key unless kept
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_visible <= 1'b1;
        end else if (clk_en && key.valid && !cfg.status_keep) begin
            status_visible <= 1'b0; // R4
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            kbd_bell <= 1'b0;
        end else if (clk_en) begin
            kbd_bell <= bell_request; // R16
        end
    end

    // Sweep timing: line period from frequency, frame in 12-line cells
    logic [9:0] line_cnt_reg;
    logic [9:0] line_len;
    logic [3:0] scan_reg;
    logic hs_act_reg;
    logic vs_act_reg;
    assign line_len = cfg.freq_60 ? 10'(`CPD_HSWEEP_60_CYC - 1) : 10'(`CPD_HSWEEP_50_CYC - 1);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            line_cnt_reg <= 10'h0;
            text_col <= 7'h0;
        end else if (clk_en) begin
            if (line_cnt_reg >= line_len) begin
                line_cnt_reg <= 10'h0; // R6
                text_col <= 7'h0;
            end else begin
                line_cnt_reg <= line_cnt_reg + 10'h1;
                if (text_col != 7'(`CPD_COLUMNS - 1)) begin
                    text_col <= text_col + 7'h1; // R17
                end
            end
        end
    end
    logic line_end;
    assign line_end = line_cnt_reg >= line_len;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scan_reg <= 4'h0;
            text_row <= 5'h0;
        end else if (clk_en && line_end) begin
            if (scan_reg == 4'(`CPD_CELL_H - 1)) begin
                scan_reg <= 4'h0;
                text_row <= (text_row == 5'(`CPD_TOTAL_ROWS)) ? 5'h0 : text_row + 5'h1; // R17
            end else begin
                scan_reg <= scan_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hs_act_reg <= 1'b0;
            vs_act_reg <= 1'b0;
            hsync <= 1'b1;
            vsync <= 1'b1;
        end else if (clk_en) begin
            hs_act_reg <= line_cnt_reg >= (line_len - 10'(`CPD_HSYNC_CYC));
            vs_act_reg <= text_row == 5'(`CPD_TOTAL_ROWS) && scan_reg < 4'(`CPD_VSYNC_LINES);
            hsync <= cfg.hsync_high ? hs_act_reg : !hs_act_reg; // R14
            vsync <= cfg.vsync_high ? vs_act_reg : !vs_act_reg; // R13
        end
    end

    a_cfg_hold: assert property (@(posedge clk) disable iff (!rst_n)
        cap_done_reg && $past(cap_done_reg) && $past(rst_n) |-> $stable(cfg)) // R19
        else $error("Config changed after capture");
    a_baud_map: assert property (@(posedge clk) disable iff (!rst_n)
        cap_done_reg |-> baud_rate == baud_of(cfg.baud_code)) // R1
        else $error("Baud rate does not match code");
    a_status_keep: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.status_keep && cap_done_reg |-> status_visible) // R4
        else $error("Status row removed while kept");
    a_status_drop: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && key.valid && !cfg.status_keep |=> !status_visible) // R4
        else $error("Status row not removed on key");
    a_bell_follow: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && $past(clk_en) && $past(rst_n) |-> kbd_bell == $past(bell_request)) // R16
        else $error("Bell does not follow request");
    a_hsync_pol: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && $past(clk_en) && $past(rst_n) |->
        hsync == ($past(cfg.hsync_high) ? $past(hs_act_reg) : !$past(hs_act_reg))) // R14
        else $error("Hsync polarity wrong");
    a_vsync_pol: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && $past(clk_en) && $past(rst_n) |->
        vsync == ($past(cfg.vsync_high) ? $past(vs_act_reg) : !$past(vs_act_reg))) // R13
        else $error("Vsync polarity wrong");
    a_row_range: assert property (@(posedge clk) disable iff (!rst_n)
        text_row <= 5'(`CPD_TOTAL_ROWS) && text_col < 7'(`CPD_COLUMNS)) // R17
        else $error("Screen position out of range");
    a_key_stop: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(key.valid) |-> $past(rx_state_reg) == RX_STOP && $past(kbd_rx)) // R15
        else $error("Key without valid stop bit");
    a_key_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && key.valid |=> !key.valid) // R15
        else $error("Key valid longer than one cycle");

    sequence s_line_end;
        clk_en && line_end;
    endsequence
    a_col_restart: assert property (@(posedge clk) disable iff (!rst_n)
        s_line_end |=> text_col == 7'h0 && line_cnt_reg == 10'h0) // R6
        else $error("Line did not restart");
    a_row_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && line_end && scan_reg == 4'(`CPD_CELL_H - 1)
        && text_row == 5'(`CPD_TOTAL_ROWS) |=> text_row == 5'h0) // R17
        else $error("Row count did not wrap");

    // Enable low freezes every counter and output
    a_clk_freeze: assert property (@(posedge clk) disable iff (!rst_n)
        !clk_en |=> $stable(line_cnt_reg) && $stable(rx_state_reg) && $stable(kbd_bell)
        && $stable(hsync) && $stable(text_col))
        else $error("State moved while enable low");
endmodule : cpd_decoder

// ---- sim/cpd_kbd_model.sv ----
// Keyboard side: sends async serial frames into the decoder.
// Assumes the decoder is set to BIT clk cycles per keyboard bit.
`timescale 1ns/1ps
module cpd_kbd_model #(
    parameter int BIT = 16
) (
    input wire logic clk,
    output logic serial_out
);
    initial serial_out = 1'b1;

    // Start bit, 8 data bits LSB first, then stop bit (bad if stop_ok low)
    task automatic send(input logic [7:0] d, input logic stop_ok);
        logic [9:0] fr;
        fr = {stop_ok, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            serial_out = fr[i];
            repeat (BIT) @(posedge clk);
            #10;
        end
        serial_out = 1'b1;
    endtask : send
endmodule : cpd_kbd_model

// ---- sim/cpd_decoder_bench.sv ----
// Self-checking bench for the configuration decoder.
// Assumes cpd_pkg and cpd_kbd_model are compiled first.
`timescale 1ns/1ps
module cpd_decoder_bench;
    import cpd_pkg::*;
    localparam logic [14:0] BAUD [16] = '{15'h4B00, 15'h2580, 15'h12C0, 15'h0960,
        15'h0708, 15'h04B0, 15'h0258, 15'h012C, 15'h0096, 15'h006E, 15'h2580,
        15'h2580, 15'h2580, 15'h2580, 15'h2580, 15'h2580};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sw1 = 8'hFF;
    logic [7:0] sw2 = 8'hFF;
    logic [2:0] jmp = 3'h0;
    logic bell_req = 1'b0;
    logic kbd_line;
    cpd_cfg_s cfg;
    cpd_cfg_s cfg_exp;
    cpd_key_s key;
    logic [14:0] baud_rate;
    logic status_visible;
    logic kbd_bell;
    logic hsync;
    logic vsync;
    logic [6:0] text_col;
    logic [4:0] text_row;
    logic clk_en = 1'b1;
    logic [7:0] key_last = 8'h00;
    logic [7:0] kd;
    int err_total = 0;
    int n_tests = 0;
    int seed = 78688;
    int key_cnt = 0;
    int cnt0;
    int per;

    always #50 clk = ~clk;

    cpd_kbd_model #(.BIT(16)) i_cpd_kbd_model (.clk(clk), .serial_out(kbd_line));

    cpd_decoder i_cpd_decoder (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .first_config_switch_bank(sw1), .second_config_switch_bank(sw2),
        .line_standard_jumper(jmp[2]), .horizontal_polarity_jumper(jmp[1]),
        .vertical_polarity_jumper(jmp[0]), .kbd_serial_in(kbd_line),
        .kbd_bit_cycles(16'h000F), .bell_request(bell_req), .cfg(cfg),
        .baud_rate(baud_rate), .status_visible(status_visible), .key(key),
        .kbd_bell(kbd_bell), .hsync(hsync), .vsync(vsync), .text_col(text_col),
        .text_row(text_row)
    );

    always @(posedge clk) begin
        if (key.valid === 1'b1) begin
            key_cnt <= key_cnt + 1;
            key_last <= key.data;
        end
    end

    // Switches read 1 when off
    function automatic cpd_cfg_s cfg_of(input logic [7:0] a, input logic [7:0] b,
                                        input logic [2:0] j);
        return '{a[3:0], ~a[4], ~a[5], ~a[6], ~a[7], ~b[0], b[1], b[2], b[3], ~b[4],
                 ~b[5], ~b[6], ~b[7], j[0], j[1], j[2]};
    endfunction : cfg_of

    task automatic tick;
        @(posedge clk);
        #10;
    endtask : tick

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // Start-to-start cycles of the active hsync level
    task automatic line_len(output int n);
        int g;
        n = 0;
        g = 0;
        while (hsync !== cfg_exp.hsync_high && g < 2000) begin
            tick();
            g++;
        end
        while (hsync === cfg_exp.hsync_high && n < 2000) begin
            tick();
            n++;
        end
        while (hsync !== cfg_exp.hsync_high && n < 2000) begin
            tick();
            n++;
        end
    endtask : line_len

    initial begin
        for (int it = 0; it < 18; it++) begin
            sw1 = 8'($random(seed));
            if (it < 16) begin
                sw1[3:0] = 4'(it);
            end
            sw2 = 8'($random(seed));
            jmp = 3'($random(seed));
            rst_n = 1'b0;
            repeat (6) tick();
            check(32'(cfg), 32'h0);
            check(32'(baud_rate), 32'h4B00);
            check(32'(status_visible), 32'h1);
            cfg_exp = cfg_of(sw1, sw2, jmp);
            rst_n = 1'b1;
            repeat (6) tick();
            check(32'(cfg), 32'(cfg_exp));
            check(32'(baud_rate), 32'(BAUD[sw1[3:0]]));
            check(32'({hsync, vsync}), 32'({~jmp[1], ~jmp[0]}));
            sw1 = ~sw1;
            sw2 = ~sw2;
            jmp = ~jmp;
            repeat (4) tick();
            check(32'(cfg), 32'(cfg_exp));
            kd = 8'($random(seed));
            cnt0 = key_cnt;
            if (it == 3) begin
                i_cpd_kbd_model.send(~kd, 1'b0);
                repeat (20) tick();
                check(32'(key_cnt - cnt0), 32'h0);
            end
            i_cpd_kbd_model.send(kd, 1'b1);
            repeat (20) tick();
            check(32'(key_cnt - cnt0), 32'h1);
            check(32'(key_last), 32'(kd));
            check(32'(status_visible), 32'(cfg_exp.status_keep));
            bell_req = it[0];
            tick();
            check(32'(kbd_bell), 32'(it[0]));
            line_len(per);
            check(32'(per), cfg_exp.freq_60 ? 32'h0203 : 32'h022B);
            check(32'(text_col), 32'h4F);
            check(32'(text_row > 5'h19), 32'h0);
            clk_en = 1'b0;
            bell_req = ~it[0];
            repeat (3) tick();
            check(32'({kbd_bell, text_col}), 32'({it[0], 7'h4F}));
            clk_en = 1'b1;
        end
        end_sim();
    end

    initial begin
        #(100 * 60000);
        err_total++;
        end_sim();
    end
endmodule : cpd_decoder_bench
